// ===== src/mvd_top.sv
// Magnetometer control, status flags and vector-magnitude change detector
//
// Overview of operation
// R1: Bit clear: subtract stored hard-iron offsets
// R2: Bit set: output samples without offsets
// R3: Auto-sleep uses sleep oversampling code field
// R4: Per-axis bit clear: threshold refreshes all references
// R5: Per-axis bit set: refresh only triggering axis
// R6: Z self-test follows its control bit
// R7: Planar self-test on when field nonzero
// R8: Decimation looked up from rate and code
// R9: Threshold flag set on threshold event
// R10: Vector-magnitude flag set on change event
// R11: Data-ready flag set on new sample
// R12: Event when distance exceeds threshold past debounce
// R13: Compare decimated outputs against latched references
// R14: Zero references detect absolute field magnitude
// R15: References held internally, not register visible
// R16: Threshold is 15-bit unsigned, 0.1 uT
// R17: Debounce counts output data periods
// R18: Latched flag holds until source register read
// R19: Compare squared distance against squared threshold
`timescale 1ns/1ps
module mvd_top (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Register access port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Incoming decimated samples and stored offsets
  input wire logic SAMPLE_VALID,
  input wire logic signed [15:0] SAMPLE_X,
  input wire logic signed [15:0] SAMPLE_Y,
  input wire logic signed [15:0] SAMPLE_Z,
  input wire logic signed [15:0] OFFSET_X,
  input wire logic signed [15:0] OFFSET_Y,
  input wire logic signed [15:0] OFFSET_Z,
  // Operating mode
  input wire logic AUTO_SLEEP,
  input wire logic [2:0] ACTIVE_OS_CODE,
  input wire logic [2:0] RATE_CODE,
  // Threshold detector handshake
  input wire logic THS_EVENT,
  input wire logic [2:0] THS_AXIS,
  output logic [2:0] THS_REF_LOAD,
  // Vector-magnitude configuration
  input wire logic VECM_ENABLE,
  input wire logic VECM_LATCH,
  input wire logic VECM_NO_UPDATE,
  input wire logic VECM_CLEAR_BELOW,
  input wire logic [14:0] VECM_THRESHOLD,
  input wire logic [7:0] VECM_COUNT,
  // Corrected or raw output data
  output logic OUT_VALID,
  output logic signed [15:0] OUT_X,
  output logic signed [15:0] OUT_Y,
  output logic signed [15:0] OUT_Z,
  // Sensor front-end controls
  output logic [2:0] OVERSAMPLING_RATIO,
  output logic [10:0] DECIMATION,
  output logic SELFTEST_Z,
  output logic SELFTEST_XY
);
  // ****************************************
  // Functions
  // ****************************************
  // Decimation count for a rate code and oversampling code
  function automatic logic [10:0] dec_lookup(input logic [2:0] rate, input logic [2:0] oversampling_ratio);
    logic [4:0] expo;
    logic [4:0] k;
    expo = 5'h00;
    k = (oversampling_ratio == 3'h0) ? 5'h00 : {2'b00, oversampling_ratio} - 5'h01;
    expo = k + {1'b0, mvd_pkg::DEC_BIAS[rate]};
    if (expo < {1'b0, mvd_pkg::DEC_OFFSET} + {1'b0, mvd_pkg::DEC_MIN_EXP}) begin
      expo = {1'b0, mvd_pkg::DEC_MIN_EXP};
    end else begin
      expo = expo - {1'b0, mvd_pkg::DEC_OFFSET};
    end
    return 11'h001 << expo;
  endfunction

  // Squared signed difference of two samples
  function automatic logic [33:0] sq_diff(input logic signed [15:0] a, input logic signed [15:0] b);
    logic signed [16:0] d;
    d = 17'(a) - 17'(b);
    return 34'(34'(d) * 34'(d));
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0] ctrl3; // Control register three
  logic flag_ths; // Sticky threshold flag
  logic flag_drdy; // Sticky data-ready flag
  logic flag_vecm_l; // Latched vector-magnitude flag
  logic src_read; // Host read of event source register
  logic signed [15:0] ref_x; // Internal references, no register path
  logic signed [15:0] ref_y;
  logic signed [15:0] ref_z;
  logic [8:0] dbc; // Debounce counter, saturates one above count
  logic cmp_valid; // Fresh output waiting for comparison
  logic [35:0] sq_sum; // Squared distance
  logic [29:0] ths_sq; // Squared threshold
  logic over; // Distance above threshold
  logic [8:0] next_dbc; // Debounce counter next value
  logic fire; // Debounced event this cycle
  logic vecm_now; // Real-time event condition
  mvd_pkg::vm_state_type vm_state;

  assign src_read = REG_RD && (REG_ADDR == mvd_pkg::SRC_ADDR);

  // ****************************************
  // Control register
  // ****************************************
  // Host writes to control register three
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ctrl3 <= mvd_pkg::CTRL3_RESET;
    end else if (REG_WR && REG_ADDR == mvd_pkg::CTRL3_ADDR) begin
      ctrl3 <= REG_WDATA;
    end
  end

  // Front-end controls, all registered
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      OVERSAMPLING_RATIO <= 3'h0;
      DECIMATION <= 11'h000;
      SELFTEST_Z <= 1'b0;
      SELFTEST_XY <= 1'b0;
    end else begin
      // Sleep code replaces active code while asleep
      OVERSAMPLING_RATIO <= AUTO_SLEEP ? ctrl3[mvd_pkg::CTRL3_SLOS_LSB +: 3] : ACTIVE_OS_CODE; // see R3
      DECIMATION <= dec_lookup(RATE_CODE,
        AUTO_SLEEP ? ctrl3[mvd_pkg::CTRL3_SLOS_LSB +: 3] : ACTIVE_OS_CODE); // see R8
      SELFTEST_Z <= ctrl3[mvd_pkg::CTRL3_STZ_BIT]; // see R6
      SELFTEST_XY <= |ctrl3[mvd_pkg::CTRL3_STXY_LSB +: 2]; // see R7
    end
  end

  // ****************************************
  // Output data path
  // ****************************************
  // Offset subtraction, wraps at 16 bits
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      OUT_VALID <= 1'b0;
      OUT_X <= 16'sh0000;
      OUT_Y <= 16'sh0000;
      OUT_Z <= 16'sh0000;
    end else begin
      OUT_VALID <= SAMPLE_VALID;
      if (SAMPLE_VALID) begin
        if (ctrl3[mvd_pkg::CTRL3_RAW_BIT]) begin
          // Uncorrected samples
          OUT_X <= SAMPLE_X; // see R2
          OUT_Y <= SAMPLE_Y; // see R2
          OUT_Z <= SAMPLE_Z; // see R2
        end else begin
          // Hard-iron corrected samples
          OUT_X <= SAMPLE_X - OFFSET_X; // see R1
          OUT_Y <= SAMPLE_Y - OFFSET_Y; // see R1
          OUT_Z <= SAMPLE_Z - OFFSET_Z; // see R1
        end
      end
    end
  end

  // ****************************************
  // Threshold reference update
  // ****************************************
  // Selects which axis references the threshold event reloads
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      THS_REF_LOAD <= 3'h0;
    end else if (THS_EVENT) begin
      // Only triggering axis, or all three
      THS_REF_LOAD <= ctrl3[mvd_pkg::CTRL3_AXUPD_BIT] ? THS_AXIS : 3'h7; // see R4 see R5
    end else begin
      THS_REF_LOAD <= 3'h0;
    end
  end

  // ****************************************
  // Vector-magnitude detector
  // ****************************************
  // Squared distance against squared threshold
  always_comb begin
    sq_sum = 36'(sq_diff(OUT_X, ref_x)) + 36'(sq_diff(OUT_Y, ref_y)) + 36'(sq_diff(OUT_Z, ref_z)); // see R13
    ths_sq = 30'(VECM_THRESHOLD) * 30'(VECM_THRESHOLD); // see R16
    over = sq_sum > 36'(ths_sq); // see R19 see R14
  end

  // Debounce step per output sample, one per effective data period
  always_comb begin
    next_dbc = dbc;
    if (over) begin
      if (dbc <= {1'b0, VECM_COUNT}) begin
        next_dbc = dbc + 9'h001; // see R17
      end
    end else if (VECM_CLEAR_BELOW) begin
      next_dbc = 9'h000;
    end else if (dbc != 9'h000) begin
      next_dbc = dbc - 9'h001;
    end
    fire = cmp_valid && (vm_state == mvd_pkg::VM_RUN) && over && (next_dbc > {1'b0, VECM_COUNT}); // see R12
  end

  // Sequencer: arm on enable, latch references from first output
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      vm_state <= mvd_pkg::VM_OFF;
    end else begin
      case (vm_state)
        mvd_pkg::VM_OFF: begin
          if (VECM_ENABLE) begin
            vm_state <= mvd_pkg::VM_ARM;
          end
        end
        mvd_pkg::VM_ARM: begin
          if (!VECM_ENABLE) begin
            vm_state <= mvd_pkg::VM_OFF;
          end else if (OUT_VALID) begin
            vm_state <= mvd_pkg::VM_RUN;
          end
        end
        mvd_pkg::VM_RUN: begin
          if (!VECM_ENABLE) begin
            vm_state <= mvd_pkg::VM_OFF;
          end
        end
        default: begin
          vm_state <= mvd_pkg::VM_OFF;
        end
      endcase
    end
  end

  // Comparison strobe one cycle after each new output in VM_RUN
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      cmp_valid <= 1'b0;
    end else begin
      cmp_valid <= OUT_VALID && (vm_state == mvd_pkg::VM_RUN);
    end
  end

  // Internal references: loaded on arming, and on events unless VECM_NO_UPDATE
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ref_x <= 16'sh0000;
      ref_y <= 16'sh0000;
      ref_z <= 16'sh0000;
    end else if ((vm_state == mvd_pkg::VM_ARM && OUT_VALID) || (fire && !VECM_NO_UPDATE)) begin
      ref_x <= OUT_X; // see R15
      ref_y <= OUT_Y;
      ref_z <= OUT_Z;
    end
  end

  // Debounce counter, restarted after each event
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      dbc <= 9'h000;
    end else if (vm_state != mvd_pkg::VM_RUN || fire) begin
      dbc <= 9'h000;
    end else if (cmp_valid) begin
      dbc <= next_dbc; // see R17
    end
  end

  // Real-time event condition, held from fire to next comparison
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      vecm_now <= 1'b0;
    end else if (vm_state != mvd_pkg::VM_RUN) begin
      vecm_now <= 1'b0;
    end else if (cmp_valid) begin
      vecm_now <= fire; // see R10
    end
  end

  // ****************************************
  // Event flags
  // ****************************************
  // Sticky flags, the vector-magnitude one only with VECM_LATCH: a set in the read cycle wins over the clear
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      flag_ths <= 1'b0;
      flag_drdy <= 1'b0;
      flag_vecm_l <= 1'b0;
    end else begin
      flag_ths <= THS_EVENT || (flag_ths && !src_read); // see R9
      flag_drdy <= OUT_VALID || (flag_drdy && !src_read); // see R11
      flag_vecm_l <= fire || (flag_vecm_l && !src_read && VECM_LATCH); // see R18
    end
  end

  // Register read data
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        mvd_pkg::CTRL3_ADDR: begin
          REG_RDATA <= ctrl3;
        end
        mvd_pkg::SRC_ADDR: begin
          REG_RDATA <= {5'h00, flag_ths, VECM_LATCH ? flag_vecm_l : vecm_now, flag_drdy}; // see R10
        end
        default: begin
          REG_RDATA <= 8'h00;
        end
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  corrected_out_a: assert property (SAMPLE_VALID && !ctrl3[7] |=> OUT_X == $past(SAMPLE_X) - $past(OFFSET_X)) // see R1
    else $error("corrected output mismatch");
  raw_out_a: assert property (SAMPLE_VALID && ctrl3[7] |=> OUT_Y == $past(SAMPLE_Y)) // see R2
    else $error("raw output mismatch");
  sleep_osr_a: assert property (AUTO_SLEEP |=> OVERSAMPLING_RATIO == $past(ctrl3[6:4])) // see R3
    else $error("sleep oversampling not applied");
  all_axes_a: assert property (THS_EVENT && !ctrl3[3] |=> THS_REF_LOAD == 3'h7) // see R4
    else $error("threshold did not reload all axes");
  one_axis_a: assert property (THS_EVENT && ctrl3[3] |=> THS_REF_LOAD == $past(THS_AXIS)) // see R5
    else $error("threshold reload wrong axis");
  selftest_z_a: assert property (##1 SELFTEST_Z == $past(ctrl3[2])) // see R6
    else $error("z self-test mismatch");
  selftest_xy_a: assert property (ctrl3[1:0] == 2'b00 |=> !SELFTEST_XY) // see R7
    else $error("planar self-test on with zero field");
  dec_fast_a: assert property (RATE_CODE == 3'h7 && $stable(RATE_CODE) |=> DECIMATION == 11'h002) // see R8
    else $error("fastest rate decimation not two");
  ths_flag_a: assert property (THS_EVENT |=> flag_ths) // see R9
    else $error("threshold flag not set");
  drdy_flag_a: assert property (OUT_VALID |=> flag_drdy) // see R11
    else $error("data-ready flag not set");
  fire_cause_a: assert property (fire |-> over && cmp_valid) // see R12
    else $error("event without distance above threshold");
  latch_hold_a: assert property (VECM_LATCH && flag_vecm_l && !src_read |=> flag_vecm_l) // see R18
    else $error("latched flag lost before read");
  ref_update_a: assert property (fire && !VECM_NO_UPDATE |=> ref_x == $past(OUT_X) && dbc == 9'h000) // see R13
    else $error("reference not refreshed on event");

  cov_event_c: cover property (fire);
  cov_latched_read_c: cover property (flag_vecm_l && src_read);
  cov_arm_run_c: cover property (vm_state == mvd_pkg::VM_ARM ##1 vm_state == mvd_pkg::VM_RUN);
endmodule

// ===== src/mvd_pkg.sv
// Package: register map, field layout, reset values and lookup constants of the magnetometer control block
package mvd_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] CTRL3_ADDR = 8'h5D; // Control register three
  localparam logic [7:0] SRC_ADDR = 8'h5E; // Event source register
  // ****************************************
  // Control register three fields
  // ****************************************
  localparam int CTRL3_RAW_BIT = 7; // Uncorrected output select
  localparam int CTRL3_SLOS_LSB = 4; // Sleep oversampling code, bits 6:4
  localparam int CTRL3_AXUPD_BIT = 3; // Per-axis threshold reference update
  localparam int CTRL3_STZ_BIT = 2; // Z self-test
  localparam int CTRL3_STXY_LSB = 0; // Planar self-test field, bits 1:0
  localparam logic [7:0] CTRL3_RESET = 8'h00; // Reset value
  // ****************************************
  // Event source register fields
  // ****************************************
  localparam int SRC_THS_BIT = 2; // Threshold event flag
  localparam int SRC_VECM_BIT = 1; // Vector-magnitude event flag
  localparam int SRC_DRDY_BIT = 0; // Data-ready flag
  // ****************************************
  // Widths
  // ****************************************
  localparam int SAMPLE_W = 16; // Magnetic sample width
  localparam int THS_W = 15; // Vector-magnitude threshold width
  localparam int CNT_W = 8; // Debounce count width
  localparam int DEC_W = 11; // Decimation count width
  localparam int SQSUM_W = 36; // Sum of three squared 17-bit differences
  // ****************************************
  // Decimation lookup: exponent bias per rate code, 1.56 Hz up to 800 Hz
  // ****************************************
  localparam logic [3:0] DEC_BIAS [8] = '{4'hA, 4'h8, 4'h7, 4'h5, 4'h4, 4'h3, 4'h2, 4'h0};
  localparam logic [3:0] DEC_OFFSET = 4'h6; // Bias subtracted from each entry
  localparam logic [3:0] DEC_MIN_EXP = 4'h1; // Smallest decimation is two
  // ****************************************
  // Vector-magnitude sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    VM_OFF = 3'b001, // Function disabled
    VM_ARM = 3'b010, // Wait for first output to latch references
    VM_RUN = 3'b100 // Comparing each output against references
  } vm_state_type;
endpackage

// ===== dv/mvd_host.sv
// Host model that reaches the control block registers one byte at a time
`timescale 1ns/1ps
module mvd_host (
  // Clock
  input wire logic mclk,
  // Register access port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // ****************************************
  // Idle state at time zero
  // ****************************************
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // ****************************************
  // Access tasks
  // ****************************************
  // One write; released lines carry the inverse so stale values never look valid
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge mclk);
    reg_addr <= addr;
    reg_wdata <= data;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~addr;
    reg_wdata <= ~data;
  endtask
  // One read; the byte is taken the cycle after the strobe is seen
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge mclk);
    reg_addr <= addr;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~addr;
    @(posedge mclk);
    #1;
    data = reg_rdata;
  endtask
endmodule

// ===== dv/test_mvd_top.sv
// Self-checking bench for the magnetometer control and vector-magnitude block
`timescale 1ns/1ps
module test_mvd_top;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic mclk, sys_rst, reg_wr, reg_rd, smp_v, auto_sleep, ths_ev, vm_en, vm_latch, vm_noupd, vm_clr;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, vm_cnt;
  logic signed [15:0] sx, sy, sz, ox, oy, oz, out_x, out_y, out_z;
  logic [2:0] act_os, rate, ths_axis, ths_load, oversampling_ratio;
  logic [14:0] vm_ths;
  logic [10:0] dec;
  logic out_v, st_z, st_xy;
  int err_count, check_count;
  localparam logic [7:0] C3 = mvd_pkg::CTRL3_ADDR;
  localparam logic [7:0] SR = mvd_pkg::SRC_ADDR;
  // Clock, 8 ns period
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // ****************************************
  // Design and host model
  // ****************************************
  mvd_top i_mvd_top (.MCLK(mclk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SAMPLE_VALID(smp_v), .SAMPLE_X(sx),
    .SAMPLE_Y(sy), .SAMPLE_Z(sz), .OFFSET_X(ox), .OFFSET_Y(oy), .OFFSET_Z(oz), .AUTO_SLEEP(auto_sleep),
    .ACTIVE_OS_CODE(act_os), .RATE_CODE(rate), .THS_EVENT(ths_ev), .THS_AXIS(ths_axis),
    .THS_REF_LOAD(ths_load), .VECM_ENABLE(vm_en), .VECM_LATCH(vm_latch), .VECM_NO_UPDATE(vm_noupd),
    .VECM_CLEAR_BELOW(vm_clr), .VECM_THRESHOLD(vm_ths), .VECM_COUNT(vm_cnt), .OUT_VALID(out_v),
    .OUT_X(out_x), .OUT_Y(out_y), .OUT_Z(out_z), .OVERSAMPLING_RATIO(oversampling_ratio), .DECIMATION(dec),
    .SELFTEST_Z(st_z), .SELFTEST_XY(st_xy));
  mvd_host i_mvd_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // ****************************************
  // Compare, access and closing tasks
  // ****************************************
  // Register byte compare
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: register byte %h, wanted %h", $time, got, exp);
    end
  endtask
  // Port value compare
  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: port value %h, wanted %h", $time, got, exp);
    end
  endtask
  // Read a register and compare it
  task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
    i_mvd_host.read_reg(addr, rd);
    chk_reg(rd, exp);
  endtask
  // One sample vector; afterwards the lines carry the inverse as filler
  task automatic send(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    @(posedge mclk);
    smp_v <= 1'b1;
    sx <= x;
    sy <= y;
    sz <= z;
    @(posedge mclk);
    smp_v <= 1'b0;
    sx <= ~x;
    sy <= ~y;
    sz <= ~z;
    #1;
    chk_out({15'h0000, out_v}, 16'h0001);
    repeat (4) @(posedge mclk);
  endtask
  // One threshold event pulse, then the reference reload mask
  task automatic ths_pulse(input logic [2:0] axis, input logic [2:0] exp);
    @(posedge mclk);
    ths_ev <= 1'b1;
    ths_axis <= axis;
    @(posedge mclk);
    ths_ev <= 1'b0;
    #1;
    chk_out({13'h0000, ths_load}, {13'h0000, exp});
  endtask
  // Decimation expected from the rate row and code column
  function automatic logic [15:0] dec_want(input int r, input int c);
    int base[8] = '{10, 8, 7, 5, 4, 3, 2, 1};
    int e;
    e = base[r] - 7 + ((c == 0) ? 1 : c);
    if (e < 1) e = 1;
    return 16'(1 << e);
  endfunction
  // Verdict and end of run
  task automatic close_out();
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    sys_rst = 1'b1;
    smp_v = 1'b0;
    sx = 16'h0000;
    sy = 16'h0000;
    sz = 16'h0000;
    ox = 16'h0010;
    oy = 16'hFFFB;
    oz = 16'h0100;
    auto_sleep = 1'b0;
    act_os = 3'h0;
    rate = 3'h0;
    ths_ev = 1'b0;
    ths_axis = 3'h0;
    vm_en = 1'b0;
    vm_latch = 1'b1;
    vm_noupd = 1'b0;
    vm_clr = 1'b1;
    vm_ths = 15'h000A;
    vm_cnt = 8'h01;
    err_count = 0;
    check_count = 0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    // Reset value, read-only source, unmapped place
    rdchk(C3, mvd_pkg::CTRL3_RESET);
    i_mvd_host.write_reg(SR, 8'hFF);
    rdchk(SR, 8'h00);
    i_mvd_host.write_reg(8'h5F, 8'hFF);
    rdchk(8'h5F, 8'h00);
    // Self-test enables for every low code, with read-back
    for (int v = 0; v < 8; v++) begin
      i_mvd_host.write_reg(C3, 8'(v));
      repeat (2) @(posedge mclk);
      #1;
      chk_out({15'h0000, st_z}, {15'h0000, v[2]});
      chk_out({15'h0000, st_xy}, {15'h0000, |v[1:0]});
      rdchk(C3, 8'(v));
    end
    // Sleep code replaces active code only in auto-sleep
    i_mvd_host.write_reg(C3, 8'h50);
    act_os <= 3'h2;
    auto_sleep <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk_out({13'h0000, oversampling_ratio}, 16'h0005);
    @(posedge mclk);
    auto_sleep <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk_out({13'h0000, oversampling_ratio}, 16'h0002);
    // Decimation for every rate and code
    for (int r = 0; r < 8; r++) begin
      for (int c = 0; c < 8; c++) begin
        @(posedge mclk);
        rate <= 3'(r);
        act_os <= 3'(c);
        repeat (3) @(posedge mclk);
        #1;
        chk_out({5'h00, dec}, dec_want(r, c));
      end
    end
    // Threshold reference reload, all axes then one axis
    i_mvd_host.write_reg(C3, 8'h00);
    ths_pulse(3'b010, 3'b111);
    i_mvd_host.write_reg(C3, 8'h08);
    ths_pulse(3'b100, 3'b100);
    repeat (3) @(posedge mclk);
    rdchk(SR, 8'h04);
    rdchk(SR, 8'h00);
    // Offset correction with wrap, then raw output
    i_mvd_host.write_reg(C3, 8'h00);
    send(16'h1000, 16'h0020, 16'h8005);
    chk_out(out_x, 16'h0FF0);
    chk_out(out_y, 16'h0025);
    chk_out(out_z, 16'h7F05);
    rdchk(SR, 8'h01);
    rdchk(SR, 8'h00);
    i_mvd_host.write_reg(C3, 8'h80);
    send(16'h1000, 16'h0020, 16'h8005);
    chk_out(out_x, 16'h1000);
    chk_out(out_z, 16'h8005);
    rdchk(SR, 8'h01);
    // Vector magnitude: equal to threshold is no event, debounce of one
    @(posedge mclk);
    vm_en <= 1'b1;
    send(16'h0000, 16'h0000, 16'h0000);
    send(16'h0006, 16'h0008, 16'h0000);
    send(16'h0000, 16'h0000, 16'h000B);
    rdchk(SR, 8'h01);
    send(16'h0000, 16'h0000, 16'h000B);
    send(16'h0000, 16'h0000, 16'h000B);
    rdchk(SR, 8'h03);
    rdchk(SR, 8'h00);
    // References moved to the event vector, so returning to zero trips again
    send(16'h0000, 16'h0000, 16'h0000);
    send(16'h0000, 16'h0000, 16'h0000);
    rdchk(SR, 8'h03);
    // Real-time flag, decrement below threshold, references frozen on events
    @(posedge mclk);
    vm_latch <= 1'b0;
    vm_noupd <= 1'b1;
    vm_clr <= 1'b0;
    vm_cnt <= 8'h02;
    send(16'h0000, 16'h0000, 16'h000B);
    send(16'h0000, 16'h0000, 16'h000B);
    rdchk(SR, 8'h01);
    send(16'h0000, 16'h0000, 16'h0000);
    send(16'h0000, 16'h0000, 16'h000B);
    send(16'h0000, 16'h0000, 16'h000B);
    rdchk(SR, 8'h03);
    rdchk(SR, 8'h02);
    send(16'h0000, 16'h0000, 16'h0000);
    rdchk(SR, 8'h01);
    // Zero count fires at once, only if references stayed at zero
    @(posedge mclk);
    vm_cnt <= 8'h00;
    send(16'h0000, 16'h0000, 16'h000B);
    rdchk(SR, 8'h03);
    close_out();
  end
endmodule
